/* shared/rftc_pkg.sv */
// Package with register offsets, field positions and reset values of the framing and transmitter slice.
package rftc_pkg;
  // Width of the register address.
  localparam int ADDR_W = 6;
  // Register offsets.
  localparam logic [5:0] OFF_CRC_HIGH = 6'h0E;
  localparam logic [5:0] OFF_BIT_FRAMING = 6'h0F;
  localparam logic [5:0] OFF_TX_CTRL = 6'h11;
  // Reset values.
  localparam logic [7:0] RST_BIT_FRAMING = 8'h00;
  localparam logic [7:0] RST_TX_CTRL = 8'h58;
  // Field positions in the framing adjustment register.
  localparam int ALIGN_LSB = 4;
  localparam int LAST_LSB = 0;
  // Field positions in the transmitter output control register.
  localparam int MODSEL_LSB = 5;
  localparam int INV_BIT = 3;
  localparam int CW_BIT = 2;
  localparam int EN2_BIT = 1;
  localparam int EN1_BIT = 0;
  // Highest bit position inside a buffer byte.
  localparam logic [2:0] POS_TOP = 3'h7;
  // Bit count of a complete final byte.
  localparam logic [3:0] FULL_BYTE_BITS = 4'h8;
  // Modulator input sources.
  typedef enum logic [1:0] {
    MOD_LOW = 2'h0,
    MOD_HIGH = 2'h1,
    MOD_ENCODER = 2'h2,
    MOD_EXTERNAL = 2'h3
  } rftc_modsel_t;
endpackage : rftc_pkg

/* shared/rftc_drv_if.sv */
// Interface between the register slice and the antenna driver stage.
`timescale 1ns/10ps
interface rftc_drv_if;
  logic carrier; // Synchronised carrier level.
  logic encoder_data; // Encoder output bit.
  logic ext_mod; // Synchronised external modulation level.
  rftc_pkg::rftc_modsel_t mod_sel; // Modulator source.
  logic inv2; // Second driver carrier inversion.
  logic cw2; // Second driver unmodulated carrier.
  logic en1; // First driver enable.
  logic en2; // Second driver enable.
  logic tx1; // First antenna driver level.
  logic tx2; // Second antenna driver level.
  logic modulator; // Modulator input level.
  // Register side drives the controls and reads the pins.
  modport ctrl (output carrier, encoder_data, ext_mod, mod_sel, inv2, cw2, en1, en2, input tx1, tx2, modulator);
  // Driver side reads the controls and makes the pin levels.
  modport drv (input carrier, encoder_data, ext_mod, mod_sel, inv2, cw2, en1, en2, output tx1, tx2, modulator);
endinterface : rftc_drv_if

/* rtl/rftc_outdrv.sv */
// Antenna driver stage: modulator source selection and the two driver pin levels.
`timescale 1ns/10ps
module rftc_outdrv (
  input wire logic clk_in,
  input wire logic nrst_in,
  rftc_drv_if.drv drv
);
  // Modulator level picked from the selected source.
  logic next_mod;
  // Carrier gated by modulation; modulator high blanks the carrier.
  logic mod_carrier;
  // Second driver carrier, optionally inverted.
  logic carrier2;
  // Second driver level before its enable.
  logic base2;
  logic mod_q;
  logic tx1_q;
  logic tx2_q;

  // Source selection for the modulator input.
  always_comb begin
    case (drv.mod_sel)
      rftc_pkg::MOD_LOW: next_mod = 1'b0;
      rftc_pkg::MOD_HIGH: next_mod = 1'b1;
      rftc_pkg::MOD_ENCODER: next_mod = drv.encoder_data;
      default: next_mod = drv.ext_mod;
    endcase
  end

  assign mod_carrier = drv.carrier & ~next_mod;
  assign carrier2 = drv.inv2 ? ~drv.carrier : drv.carrier;
  assign base2 = drv.cw2 ? carrier2 : (carrier2 & ~next_mod);

  // Pin levels are registered; a disabled driver holds a constant low.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mod_q <= 1'b0;
      tx1_q <= 1'b0;
      tx2_q <= 1'b0;
    end else begin
      mod_q <= next_mod;
      tx1_q <= drv.en1 ? mod_carrier : 1'b0;
      tx2_q <= drv.en2 ? base2 : 1'b0;
    end
  end

  assign drv.modulator = mod_q;
  assign drv.tx1 = tx1_q;
  assign drv.tx2 = tx2_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  property p_mod_low;
    drv.mod_sel == rftc_pkg::MOD_LOW |=> drv.modulator == 1'b0;
  endproperty
  a_mod_low: assert property (p_mod_low) else $error("modulator not low for low source");
  property p_mod_ext;
    drv.mod_sel == rftc_pkg::MOD_EXTERNAL |=> drv.modulator == $past(drv.ext_mod);
  endproperty
  a_mod_ext: assert property (p_mod_ext) else $error("modulator does not follow external pin");
  property p_tx1_off;
    !drv.en1 |=> drv.tx1 == 1'b0;
  endproperty
  a_tx1_off: assert property (p_tx1_off) else $error("first driver not constant when disabled");
  property p_tx2_off;
    !drv.en2 |=> drv.tx2 == 1'b0;
  endproperty
  a_tx2_off: assert property (p_tx2_off) else $error("second driver not constant when disabled");
  property p_tx2_cw;
    drv.en2 && drv.cw2 |=> drv.tx2 == ($past(drv.carrier) ^ $past(drv.inv2));
  endproperty
  a_tx2_cw: assert property (p_tx2_cw) else $error("second driver modulated in continuous wave");
  property p_tx2_inv;
    drv.en2 && drv.inv2 && !next_mod |=> drv.tx2 == !$past(drv.carrier);
  endproperty
  a_tx2_inv: assert property (p_tx2_inv) else $error("second driver carrier not inverted");
  property p_tx1_mod;
    drv.en1 && next_mod |=> drv.tx1 == 1'b0;
  endproperty
  a_tx1_mod: assert property (p_tx1_mod) else $error("first driver not blanked by modulation");
  c_both_on: cover property (drv.en1 && drv.en2 ##1 drv.tx1 && drv.tx2);
endmodule : rftc_outdrv

/* rtl/rftc_top.sv */
// Register slice for CRC upper byte, bit framing adjustments and transmitter output control.
`timescale 1ns/10ps
module rftc_top (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [5:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rdata_out,
  input wire logic [7:0] crc_upper_byte_in,
  input wire logic crc_done_flag_in,
  input wire logic rx_start_in,
  input wire logic rx_bit_in,
  input wire logic rx_done_in,
  input wire logic tx_done_in,
  input wire logic encoder_data_in,
  input wire logic carrier_in,
  input wire logic external_modulation_input_in,
  output logic [2:0] receive_bit_alignment_out,
  output logic [2:0] final_byte_bit_count_out,
  output logic [2:0] rx_bit_pos_out,
  output logic rx_byte_next_out,
  output logic [3:0] tx_final_bits_out,
  output logic modulator_out,
  output logic first_antenna_driver_out,
  output logic second_antenna_driver_out
);
  // Next bit position, wrapping from the top of a byte to position zero.
  function automatic logic [2:0] next_pos(input logic [2:0] pos);
    next_pos = (pos == rftc_pkg::POS_TOP) ? 3'h0 : pos + 3'h1;
  endfunction : next_pos

  // Number of bits sent from the final byte for a given field value.
  function automatic logic [3:0] final_bits(input logic [2:0] f);
    final_bits = (f == 3'h0) ? rftc_pkg::FULL_BYTE_BITS : {1'b0, f};
  endfunction : final_bits

  // Framing adjustment fields.
  logic [2:0] receive_bit_alignment;
  logic [2:0] final_byte_bit_count;
  // Transmitter output control register, all eight bits stored.
  logic [7:0] transmit_output_control;
  // Bit position tracker for the current reception.
  logic [2:0] bit_pos;
  // Pin synchronisers, two stages each.
  logic [1:0] carrier_sync;
  logic [1:0] ext_mod_sync;
  // Registered read data and derived outputs.
  logic [7:0] rdata;
  logic [2:0] pos_q;
  logic byte_next_q;
  logic [3:0] final_bits_q;
  // High during reset and in the first cycle after its release; read by an assertion.
  logic first_cycle;

  // Address decode.
  logic sel_crc;
  logic sel_bf;
  logic sel_txc;
  logic wr_bf;
  logic wr_txc;
  logic [7:0] bit_framing_adjust;
  logic [7:0] next_rdata;

  assign sel_crc = (addr_in == rftc_pkg::OFF_CRC_HIGH);
  assign sel_bf = (addr_in == rftc_pkg::OFF_BIT_FRAMING);
  assign sel_txc = (addr_in == rftc_pkg::OFF_TX_CTRL);
  assign wr_bf = wr_en_in && sel_bf;
  assign wr_txc = wr_en_in && sel_txc;
  // Reserved bits 7 and 3 of the framing register read as zero.
  assign bit_framing_adjust = {1'b0, receive_bit_alignment, 1'b0, final_byte_bit_count};

  // Read selection; unmapped addresses return zero.
  // The upper CRC byte is passed through as the engine holds it; it only means
  // something once the done flag is set, and in eight-bit mode it is meaningless.
  assign next_rdata = sel_crc ? crc_upper_byte_in :
                      sel_bf ? bit_framing_adjust :
                      sel_txc ? transmit_output_control : 8'h00;

  // Read data is registered and appears one cycle after the read strobe.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata <= 8'h00;
    end else if (rd_en_in) begin
      rdata <= next_rdata;
    end
  end

  // Alignment field; a software write in the completion cycle wins.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      receive_bit_alignment <= rftc_pkg::RST_BIT_FRAMING[rftc_pkg::ALIGN_LSB +: 3];
    end else if (wr_bf) begin
      receive_bit_alignment <= wdata_in[rftc_pkg::ALIGN_LSB +: 3];
    end else if (rx_done_in) begin
      receive_bit_alignment <= 3'h0;
    end
  end

  // Final byte bit count; a software write in the completion cycle wins.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      final_byte_bit_count <= rftc_pkg::RST_BIT_FRAMING[rftc_pkg::LAST_LSB +: 3];
    end else if (wr_bf) begin
      final_byte_bit_count <= wdata_in[rftc_pkg::LAST_LSB +: 3];
    end else if (tx_done_in) begin
      final_byte_bit_count <= 3'h0;
    end
  end

  // Transmitter output control; bits 7 and 4 are stored as software writes them.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      transmit_output_control <= rftc_pkg::RST_TX_CTRL;
    end else if (wr_txc) begin
      transmit_output_control <= wdata_in;
    end
  end

  // Bit position tracker: a reception start loads the alignment, each bit advances.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_pos <= 3'h0;
    end else if (rx_start_in) begin
      bit_pos <= receive_bit_alignment;
    end else if (rx_bit_in) begin
      bit_pos <= next_pos(bit_pos);
    end
  end

  // Position of the stored bit and a flag that the next bit opens a new byte.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pos_q <= 3'h0;
      byte_next_q <= 1'b0;
    end else if (rx_bit_in && !rx_start_in) begin
      pos_q <= bit_pos;
      byte_next_q <= (bit_pos == rftc_pkg::POS_TOP);
    end
  end

  // Count of bits that the encoder sends from the final byte.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      final_bits_q <= rftc_pkg::FULL_BYTE_BITS;
    end else begin
      final_bits_q <= final_bits(final_byte_bit_count);
    end
  end

  // Pin synchronisers; only the second stage is read.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      carrier_sync <= 2'h0;
      ext_mod_sync <= 2'h0;
    end else begin
      carrier_sync <= {carrier_sync[0], carrier_in};
      ext_mod_sync <= {ext_mod_sync[0], external_modulation_input_in};
    end
  end

  // Marks the first cycle after reset release.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  // Driver stage connection.
  rftc_drv_if drv_if ();
  assign drv_if.carrier = carrier_sync[1];
  assign drv_if.encoder_data = encoder_data_in;
  assign drv_if.ext_mod = ext_mod_sync[1];
  assign drv_if.mod_sel = rftc_pkg::rftc_modsel_t'(transmit_output_control[rftc_pkg::MODSEL_LSB +: 2]);
  assign drv_if.inv2 = transmit_output_control[rftc_pkg::INV_BIT];
  assign drv_if.cw2 = transmit_output_control[rftc_pkg::CW_BIT];
  assign drv_if.en2 = transmit_output_control[rftc_pkg::EN2_BIT];
  assign drv_if.en1 = transmit_output_control[rftc_pkg::EN1_BIT];

  rftc_outdrv u_outdrv (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .drv(drv_if.drv)
  );

  // Output assignments.
  assign rdata_out = rdata;
  assign receive_bit_alignment_out = receive_bit_alignment;
  assign final_byte_bit_count_out = final_byte_bit_count;
  assign rx_bit_pos_out = pos_q;
  assign rx_byte_next_out = byte_next_q;
  assign tx_final_bits_out = final_bits_q;
  assign modulator_out = drv_if.modulator;
  assign first_antenna_driver_out = drv_if.tx1;
  assign second_antenna_driver_out = drv_if.tx2;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  property p_crc_read;
    rd_en_in && sel_crc |=> rdata_out == $past(crc_upper_byte_in);
  endproperty
  a_crc_read: assert property (p_crc_read) else $error("upper CRC byte read wrong");
  property p_align_clear;
    rx_done_in && !wr_bf |=> receive_bit_alignment_out == 3'h0;
  endproperty
  a_align_clear: assert property (p_align_clear) else $error("alignment not cleared after reception");
  property p_last_clear;
    tx_done_in && !wr_bf |=> final_byte_bit_count_out == 3'h0;
  endproperty
  a_last_clear: assert property (p_last_clear) else $error("final bit count not cleared");
  property p_reset_zero;
    first_cycle |-> bit_framing_adjust == rftc_pkg::RST_BIT_FRAMING;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("framing register not zero after reset");
  property p_pos_start;
    rx_start_in ##1 rx_bit_in && !rx_start_in |=> rx_bit_pos_out == $past(receive_bit_alignment, 2);
  endproperty
  a_pos_start: assert property (p_pos_start) else $error("first bit not at aligned position");
  property p_pos_wrap;
    rx_bit_in && !rx_start_in && bit_pos == 3'h7 |=> rx_byte_next_out && bit_pos == 3'h0;
  endproperty
  a_pos_wrap: assert property (p_pos_wrap) else $error("bit position did not wrap");
  property p_final_bits;
    final_byte_bit_count_out == 3'h0 |=> ##1 tx_final_bits_out == 4'h8 || $past(final_byte_bit_count_out) != 3'h0;
  endproperty
  a_final_bits: assert property (p_final_bits) else $error("zero count does not send full byte");
  property p_bf_write;
    wr_bf |=> receive_bit_alignment_out == $past(wdata_in[6:4]) && final_byte_bit_count_out == $past(wdata_in[2:0]);
  endproperty
  a_bf_write: assert property (p_bf_write) else $error("framing write not stored");
  c_align7: cover property (rx_start_in && receive_bit_alignment == 3'h7 ##1 rx_bit_in ##1 rx_byte_next_out);
  c_tx_clear: cover property (final_byte_bit_count != 3'h0 && tx_done_in ##1 final_byte_bit_count == 3'h0);
  c_txc_write: cover property (wr_txc ##1 drv_if.mod_sel == rftc_pkg::MOD_EXTERNAL);
  // The upper CRC byte is only meaningful when read while the engine reports completion.
  c_crc_done_read: cover property (rd_en_in && sel_crc && crc_done_flag_in);
endmodule : rftc_top

/* tb/rftc_host.sv */
// Host processor model that reaches the register slice with single byte strobes.
`timescale 1ns/10ps
module rftc_host (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [5:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_en_out,
  output logic rd_en_out
);
  // Bus starts idle with both strobes low.
  initial begin
    addr_out = 6'h00;
    wdata_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end

  // One write; control writes keep bit 7 low and bit 4 high.
  task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= (a == rftc_pkg::OFF_TX_CTRL) ? {1'b0, d[6:5], 1'b1, d[3:0]} : d;
    wr_en_out <= 1'b1;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    // Released lines show the inverse so stale values cannot pass.
    addr_out <= ~a;
    wdata_out <= ~wdata_out;
  endtask : write_reg

  // One read; data is taken once the strobe edge has updated it.
  task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask : read_reg
endmodule : rftc_host

/* tb/tb_rftc_top.sv */
// Self-checking testbench of the framing and transmitter register slice.
`timescale 1ns/10ps
module tb_rftc_top;
  logic clk_in, nrst_in;
  logic [5:0] addr; // Register address from the host.
  logic [7:0] wdata, rdata, rd;
  logic wr_en, rd_en;
  logic [7:0] crc_byte;
  logic crc_done, rx_start, rx_bit, rx_done, tx_done, enc, car, ext;
  logic [2:0] align, last, pos;
  logic byte_next, modl, tx1, tx2;
  logic [3:0] fin_bits;
  logic [7:0] ctrl; // Control value written in the driver sweep.
  logic [2:0] expv; // Expected modulator, first and second pin.
  int bad_count = 0;
  int checks_done = 0;

  rftc_top uut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .rdata_out(rdata), .crc_upper_byte_in(crc_byte), .crc_done_flag_in(crc_done),
    .rx_start_in(rx_start), .rx_bit_in(rx_bit), .rx_done_in(rx_done), .tx_done_in(tx_done),
    .encoder_data_in(enc), .carrier_in(car), .external_modulation_input_in(ext),
    .receive_bit_alignment_out(align), .final_byte_bit_count_out(last), .rx_bit_pos_out(pos),
    .rx_byte_next_out(byte_next), .tx_final_bits_out(fin_bits), .modulator_out(modl),
    .first_antenna_driver_out(tx1), .second_antenna_driver_out(tx2));

  rftc_host host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_en_out(wr_en), .rd_en_out(rd_en));

  // 20 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Compares two values and counts the outcome.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // Pulses the reception or the transmission completion input for a single cycle.
  task automatic pulse_done(input logic is_rx);
    @(posedge clk_in);
    if (is_rx) begin
      rx_done <= 1'b1;
    end else begin
      tx_done <= 1'b1;
    end
    @(posedge clk_in);
    rx_done <= 1'b0;
    tx_done <= 1'b0;
    @(negedge clk_in);
  endtask : pulse_done

  // Expected pin levels: modulation high blanks the carrier except on the second pin in continuous wave, disabled pins stay 0.
  function automatic logic [2:0] pins(input logic [7:0] c, input logic cr, input logic e, input logic x);
    logic m;
    m = (c[6:5] == 2'h0) ? 1'b0 : (c[6:5] == 2'h1) ? 1'b1 : (c[6:5] == 2'h2) ? e : x;
    return {m, c[0] & cr & ~m, c[1] & (c[2] ? (cr ^ c[3]) : ((cr ^ c[3]) & ~m))};
  endfunction : pins

  // Guards against a hung run.
  initial begin
    repeat (60000) @(posedge clk_in);
    bad_count++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    nrst_in = 1'b0;
    {crc_done, rx_start, rx_bit, rx_done, tx_done, enc, car, ext} = 8'h00;
    crc_byte = 8'hA5;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    // Reset values and the read-only upper CRC byte.
    host.read_reg(rftc_pkg::OFF_BIT_FRAMING, rd);
    chk(rd, rftc_pkg::RST_BIT_FRAMING);
    chk({4'h0, fin_bits}, 8'h08);
    host.read_reg(rftc_pkg::OFF_TX_CTRL, rd);
    chk(rd, rftc_pkg::RST_TX_CTRL);
    crc_done <= 1'b1;
    host.write_reg(rftc_pkg::OFF_CRC_HIGH, 8'h00);
    host.read_reg(rftc_pkg::OFF_CRC_HIGH, rd);
    chk(rd, 8'hA5);
    host.read_reg(6'h3F, rd);
    chk(rd, 8'h00);
    $display("test reset_crc done");
    // Framing: alignment 7, five final bits, then wrap and self-clear.
    host.write_reg(rftc_pkg::OFF_BIT_FRAMING, 8'h75);
    host.read_reg(rftc_pkg::OFF_BIT_FRAMING, rd);
    chk(rd, 8'h75);
    chk({4'h0, fin_bits}, 8'h05);
    @(posedge clk_in);
    rx_start <= 1'b1;
    @(posedge clk_in);
    rx_start <= 1'b0;
    rx_bit <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    chk({4'h0, byte_next, pos}, 8'h0F);
    @(posedge clk_in);
    rx_bit <= 1'b0;
    @(negedge clk_in);
    chk({4'h0, byte_next, pos}, 8'h00);
    pulse_done(1'b0);
    chk({2'h0, align, last}, 8'h38);
    @(negedge clk_in);
    chk({4'h0, fin_bits}, 8'h08);
    pulse_done(1'b1);
    chk({5'h0, align}, 8'h00);
    host.read_reg(rftc_pkg::OFF_BIT_FRAMING, rd);
    chk(rd, 8'h00);
    $display("test framing done");
    // Driver sweep over every source and every enable combination.
    for (int j = 0; j < 64; j++) begin
      ctrl = {1'b0, j[5:4], 1'b1, j[3:0]};
      host.write_reg(rftc_pkg::OFF_TX_CTRL, ctrl);
      for (int c = 0; c < 2; c++) begin
        @(posedge clk_in);
        car <= c[0];
        enc <= c[0];
        ext <= ~c[0];
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        expv = pins(ctrl, c[0], c[0], ~c[0]);
        chk({7'h0, modl}, {7'h0, expv[2]});
        chk({7'h0, tx1}, {7'h0, expv[1]});
        chk({7'h0, tx2}, {7'h0, expv[0]});
      end
    end
    host.read_reg(rftc_pkg::OFF_TX_CTRL, rd);
    chk(rd, 8'h7F);
    // A reset in mid-run must bring both writable registers back to their reset values.
    host.write_reg(rftc_pkg::OFF_BIT_FRAMING, 8'h13);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    host.read_reg(rftc_pkg::OFF_BIT_FRAMING, rd);
    chk(rd, rftc_pkg::RST_BIT_FRAMING);
    host.read_reg(rftc_pkg::OFF_TX_CTRL, rd);
    chk(rd, rftc_pkg::RST_TX_CTRL);
    $display("test drivers done");
    tally_and_finish();
  end
endmodule : tb_rftc_top
